// File: hw/pswc_top.sv
// Purpose: Sleep entry and wake control for the processor core
// Assumes: Instruction strobes are one-cycle pulses issued only while running
// Notes:   Clock and power requests go to the system clock controller
//
// Decided for this implementation: the plain strobed port and the register offsets.
`include "pswc_defines.svh"

// Functional notes
// R01 - Light sleep stops the core clock, system clock keeps running.
// R02 - Deep sleep stops system clock and powers down PLL and flash.
// R03 - Deep-sleep select bit picks light or deep sleep for any entry.
// R04 - Wait-for-interrupt sleeps at once unless a wake condition already holds.
// R05 - Wait-for-event with event latch clear halts and sleeps.
// R06 - Wait-for-event with latch set clears it and keeps running.
// R07 - Send-event sets the latch; software cannot read or write it.
// R08 - Sleep-on-exit bit sleeps right after the last handler returns.
// R09 - Interrupt-type sleep wakes on an exception fit for entry, a deferred interrupt or a debug wake.
// R10 - Disable flag set, fault flag clear: interrupt wakes, handler deferred.
// R11 - Event-type sleep wakes on any exception fit for entry.
// R12 - Pending-raises-event bit: every new pending interrupt sets the event latch and wakes event-type sleep.
// R13 - Spurious wakes allowed; sleep may be re-entered immediately afterwards.
// R14 - Sleeping and deep-sleep indications drive the system clock controller.
module pswc_top (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic [`PSWC_ADDR_W-1:0]   reg_addr,
  input  wire logic [`PSWC_DATA_W-1:0]   reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [`PSWC_DATA_W-1:0]   reg_rdata,
  input  wire logic                      wait_for_interrupt_instr,
  input  wire logic                      wait_for_event_instr,
  input  wire logic                      send_event_instr,
  input  wire logic                      handler_exit_last,
  input  wire logic                      exc_entry_req,
  input  wire logic                      irq_above_priority,
  input  wire logic                      irq_new_pending,
  input  wire logic                      debug_wake,
  input  wire logic                      interrupt_disable_flag,
  input  wire logic                      fault_disable_flag,
  output logic                           core_halt,
  output logic                           core_clk_en,
  output logic                           sys_clk_en,
  output logic                           pll_power_down,
  output logic                           flash_power_down,
  output logic                           sleeping,
  output logic                           deep_sleep,
  output logic                           wfe_skip,
  output logic                           wake_pulse,
  output logic                           handler_defer
);
  import pswc_pkg::*;

  pswc_state_t                state;
  pswc_state_t                next_state;
  pswc_cause_t                cause;
  pswc_cause_t                next_cause;
  logic                       deep_sleep_select;
  logic                       sleep_on_handler_exit;
  logic                       pending_irq_raises_event;
  logic                       deep_latched;
  logic                       defer_latched;
  logic [`PSWC_CNT_W-1:0]     entry_count;
  logic [`PSWC_CNT_W-1:0]     wake_count;
  logic                       event_q;
  logic                       event_set;
  logic                       event_clear;
  logic                       wake_int;
  logic                       wake_evt;
  logic                       wake_deferred;
  logic                       enter_int;
  logic                       enter_evt;
  logic                       enter_any;
  logic                       wake_now;
  logic                       depth_next;
  logic                       wfe_skip_now;
  logic [`PSWC_DATA_W-1:0]    next_rdata;

  // Saturating increment for the statistics counters
  function automatic logic [`PSWC_CNT_W-1:0] sat_inc(input logic [`PSWC_CNT_W-1:0] v);
    if (&v) begin
      sat_inc = v;
    end else begin
      sat_inc = v + `PSWC_CNT_ONE;
    end
  endfunction

  // Pick the wake cause from the active wake terms
  function automatic pswc_cause_t pick_cause(input logic exc, input logic dfr,
                                             input logic evt, input logic dbg);
    if (exc) begin
      pick_cause = PSWC_CAUSE_EXC;
    end else if (dfr) begin
      pick_cause = PSWC_CAUSE_DEFER;
    end else if (evt) begin
      pick_cause = PSWC_CAUSE_EVENT;
    end else if (dbg) begin
      pick_cause = PSWC_CAUSE_DEBUG;
    end else begin
      pick_cause = PSWC_CAUSE_NONE;
    end
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic reg_hit(input logic wr, input logic [`PSWC_ADDR_W-1:0] addr,
                                   input logic [`PSWC_ADDR_W-1:0] off);
    reg_hit = wr && (addr == off);
  endfunction

  pswc_event_latch u_event_latch (
    .clock       (clock),
    .resetn      (resetn),
    .set_event   (event_set),
    .clear_event (event_clear),
    .event_q     (event_q)
  );

  pswc_wake_detect u_wake_detect (
    .exc_entry_req          (exc_entry_req),
    .irq_above_priority     (irq_above_priority),
    .interrupt_disable_flag (interrupt_disable_flag),
    .fault_disable_flag     (fault_disable_flag),
    .event_q                (event_q),
    .debug_wake             (debug_wake),
    .wake_int               (wake_int),
    .wake_evt               (wake_evt),
    .wake_deferred          (wake_deferred)
  );

  // Event latch sources and consumers
  always_comb begin
    event_set   = send_event_instr
                | (pending_irq_raises_event & irq_new_pending); // R07 R12
    event_clear = wfe_skip_now // R06
                | (state == PSWC_SLEEP_EVT && wake_evt);
  end

  // Sleep entry decisions taken while running
  always_comb begin
    enter_int = 1'h0;
    enter_evt = 1'h0;
    if (state == PSWC_RUN) begin
      if (wait_for_interrupt_instr && !wake_int) begin
        enter_int = 1'h1; // R04
      end else if (handler_exit_last && sleep_on_handler_exit && !wake_int) begin
        enter_int = 1'h1; // R08
      end else if (wait_for_event_instr && !event_q) begin
        enter_evt = 1'h1; // R05
      end
    end
    enter_any = enter_int | enter_evt;
  end

  // Sleep state machine; every wake returns to run so sleep can repeat
  always_comb begin
    next_state = state;
    wake_now   = 1'h0;
    next_cause = cause;
    unique case (state)
      PSWC_RUN: begin
        if (enter_int) begin
          next_state = PSWC_SLEEP_INT;
        end else if (enter_evt) begin
          next_state = PSWC_SLEEP_EVT;
        end
      end
      PSWC_SLEEP_INT: begin
        if (wake_int) begin // R09 R10 R13
          next_state = PSWC_RUN;
          wake_now   = 1'h1;
          next_cause = pick_cause(exc_entry_req, wake_deferred, 1'h0, debug_wake);
        end
      end
      PSWC_SLEEP_EVT: begin
        if (wake_evt) begin // R11 R12 R13
          next_state = PSWC_RUN;
          wake_now   = 1'h1;
          next_cause = pick_cause(exc_entry_req, wake_deferred, event_q, debug_wake);
        end
      end
      default: begin
        next_state = PSWC_RUN;
      end
    endcase
  end

  // Sleep depth this cycle, shared by the system clock, PLL, flash and deep-sleep requests
  always_comb begin
    depth_next   = enter_any ? deep_sleep_select : (deep_latched && !wake_now); // R03
    wfe_skip_now = (state == PSWC_RUN) && wait_for_event_instr && event_q; // R06
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= PSWC_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cause <= PSWC_CAUSE_NONE;
    end else begin
      cause <= next_cause;
    end
  end

  // Sleep depth is frozen at entry from the select bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      deep_latched <= 1'h0;
    end else if (enter_any) begin
      deep_latched <= deep_sleep_select; // R03
    end else if (wake_now) begin
      deep_latched <= 1'h0;
    end
  end

  // Handler deferral holds until the disable flag is cleared
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      defer_latched <= 1'h0;
    end else if (wake_now && wake_deferred && !exc_entry_req) begin
      defer_latched <= 1'h1; // R10
    end else if (!interrupt_disable_flag) begin
      defer_latched <= 1'h0;
    end
  end

  // Core clock gate and system clock request to the clock controller
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      core_halt   <= 1'h0;
      core_clk_en <= 1'h1;
      sys_clk_en  <= 1'h1;
    end else begin
      core_halt   <= (next_state != PSWC_RUN); // R04 R05
      core_clk_en <= (next_state == PSWC_RUN); // R01
      sys_clk_en  <= !depth_next; // R01 R02
    end
  end

  // PLL and flash power down only in deep sleep
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pll_power_down   <= 1'h0;
      flash_power_down <= 1'h0;
    end else begin
      pll_power_down   <= depth_next; // R02
      flash_power_down <= depth_next; // R02
    end
  end

  // Sleeping and deep-sleep indications to the clock controller
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sleeping   <= 1'h0;
      deep_sleep <= 1'h0;
    end else begin
      sleeping   <= (next_state != PSWC_RUN); // R14
      deep_sleep <= depth_next; // R14
    end
  end

  // One-cycle notices to the core
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wfe_skip   <= 1'h0;
      wake_pulse <= 1'h0;
    end else begin
      wfe_skip   <= wfe_skip_now; // R06
      wake_pulse <= wake_now;
    end
  end

  always_comb begin
    handler_defer = defer_latched;
  end

  // Statistics counters
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      entry_count <= `PSWC_CNT_RESET;
    end else if (reg_hit(reg_write, reg_addr, `PSWC_OFF_ENTRIES)) begin
      entry_count <= `PSWC_CNT_RESET;
    end else if (enter_any) begin
      entry_count <= sat_inc(entry_count);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_count <= `PSWC_CNT_RESET;
    end else if (reg_hit(reg_write, reg_addr, `PSWC_OFF_WAKES)) begin
      wake_count <= `PSWC_CNT_RESET;
    end else if (wake_now) begin
      wake_count <= sat_inc(wake_count);
    end
  end

  // System control register bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      deep_sleep_select        <= `PSWC_CTRL_RESET;
      sleep_on_handler_exit    <= `PSWC_CTRL_RESET;
      pending_irq_raises_event <= `PSWC_CTRL_RESET;
    end else if (reg_hit(reg_write, reg_addr, `PSWC_OFF_CTRL)) begin
      deep_sleep_select        <= reg_wdata[`PSWC_BIT_DEEP]; // R03
      sleep_on_handler_exit    <= reg_wdata[`PSWC_BIT_SOE]; // R08
      pending_irq_raises_event <= reg_wdata[`PSWC_BIT_SEVONP]; // R12
    end
  end

  // Read mux; the event latch is deliberately not mapped
  always_comb begin
    next_rdata = `PSWC_RDATA_RESET;
    unique case (reg_addr)
      `PSWC_OFF_CTRL: begin
        next_rdata[`PSWC_BIT_DEEP]   = deep_sleep_select;
        next_rdata[`PSWC_BIT_SOE]    = sleep_on_handler_exit;
        next_rdata[`PSWC_BIT_SEVONP] = pending_irq_raises_event;
      end
      `PSWC_OFF_STATUS: begin
        next_rdata[`PSWC_ST_STATE_HI:`PSWC_ST_STATE_LO] = state;
        next_rdata[`PSWC_ST_DEEP]                       = deep_latched;
        next_rdata[`PSWC_ST_DEFER]                      = defer_latched;
        next_rdata[`PSWC_ST_CAUSE_HI:`PSWC_ST_CAUSE_LO] = cause;
      end
      `PSWC_OFF_ENTRIES: begin
        next_rdata[`PSWC_CNT_W-1:0] = entry_count;
      end
      `PSWC_OFF_WAKES: begin
        next_rdata[`PSWC_CNT_W-1:0] = wake_count;
      end
      default: begin
        next_rdata = `PSWC_RDATA_RESET;
      end
    endcase
  end

  // Read data stands for one cycle after the read strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `PSWC_RDATA_RESET;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `PSWC_RDATA_RESET;
    end
  end

endmodule

// File: common/pswc_defines.svh
// Purpose: Named constants for the processor sleep and wake controller
// Assumes: Included by bare name from design files
// Notes:   Offsets are byte addresses on the plain register port
`ifndef PSWC_DEFINES_SVH
`define PSWC_DEFINES_SVH

`define PSWC_ADDR_W        8
`define PSWC_DATA_W        32
`define PSWC_CNT_W         16

`define PSWC_OFF_CTRL      8'h00
`define PSWC_OFF_STATUS    8'h04
`define PSWC_OFF_ENTRIES   8'h08
`define PSWC_OFF_WAKES     8'h0C

`define PSWC_BIT_SOE       1
`define PSWC_BIT_DEEP      2
`define PSWC_BIT_SEVONP    4

`define PSWC_ST_STATE_LO   0
`define PSWC_ST_STATE_HI   1
`define PSWC_ST_DEEP       2
`define PSWC_ST_DEFER      3
`define PSWC_ST_CAUSE_LO   4
`define PSWC_ST_CAUSE_HI   6

`define PSWC_CTRL_RESET    1'h0
`define PSWC_CNT_RESET     16'h0000
`define PSWC_CNT_ONE       16'h0001
`define PSWC_RDATA_RESET   32'h0000_0000

`endif

// File: common/pswc_pkg.sv
// Purpose: Types shared by the sleep and wake controller
// Assumes: Nothing
// Notes:   State and wake cause codes are read back through the status register
package pswc_pkg;

  typedef enum logic [1:0] {
    PSWC_RUN       = 2'h0,
    PSWC_SLEEP_INT = 2'h1,
    PSWC_SLEEP_EVT = 2'h2
  } pswc_state_t;

  typedef enum logic [2:0] {
    PSWC_CAUSE_NONE  = 3'h0,
    PSWC_CAUSE_EXC   = 3'h1,
    PSWC_CAUSE_DEFER = 3'h2,
    PSWC_CAUSE_EVENT = 3'h3,
    PSWC_CAUSE_DEBUG = 3'h4
  } pswc_cause_t;

endpackage

// File: hw/pswc_event_latch.sv
// Purpose: One-bit event latch for the wait-for-event path
// Assumes: Set and clear are one-cycle pulses in the clock domain
// Notes:   A set in the same cycle as a clear wins; no software access
module pswc_event_latch (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic set_event,
  input  wire logic clear_event,
  output logic      event_q
);
  import pswc_pkg::*;

  // Only instruction and pending-interrupt pulses set this latch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      event_q <= 1'h0;
    end else if (set_event) begin
      event_q <= 1'h1; // R07
    end else if (clear_event) begin
      event_q <= 1'h0;
    end
  end

endmodule

// File: hw/pswc_wake_detect.sv
// Purpose: Wake conditions for both sleep flavours
// Assumes: Interrupt controller inputs are levels in the clock domain
// Notes:   Purely combinational
module pswc_wake_detect (
  input  wire logic exc_entry_req,
  input  wire logic irq_above_priority,
  input  wire logic interrupt_disable_flag,
  input  wire logic fault_disable_flag,
  input  wire logic event_q,
  input  wire logic debug_wake,
  output logic      wake_int,
  output logic      wake_evt,
  output logic      wake_deferred
);
  import pswc_pkg::*;

  // Interrupt held back by the disable flag but still allowed to wake
  function automatic logic masked_wake(input logic irq, input logic pm, input logic fm);
    masked_wake = irq & pm & ~fm;
  endfunction

  always_comb begin
    wake_deferred = masked_wake(irq_above_priority, interrupt_disable_flag,
                                fault_disable_flag); // R10
    wake_int      = exc_entry_req | wake_deferred | debug_wake; // R09 R13
    wake_evt      = exc_entry_req | masked_wake(irq_above_priority,
                    interrupt_disable_flag, fault_disable_flag)
                    | event_q | debug_wake; // R11 R12 R13
  end

endmodule

// File: tb/pswc_checker_asserts.sv
// Purpose: Port-level checks of the sleep and wake controller
// Assumes: One clock domain, reset active low
// Notes:   Bound into every pswc_top instance
module pswc_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wait_for_interrupt_instr,
  input wire logic wait_for_event_instr,
  input wire logic send_event_instr,
  input wire logic exc_entry_req,
  input wire logic irq_above_priority,
  input wire logic irq_new_pending,
  input wire logic debug_wake,
  input wire logic interrupt_disable_flag,
  input wire logic fault_disable_flag,
  input wire logic core_halt,
  input wire logic core_clk_en,
  input wire logic sys_clk_en,
  input wire logic pll_power_down,
  input wire logic flash_power_down,
  input wire logic sleeping,
  input wire logic deep_sleep,
  input wire logic wfe_skip,
  input wire logic wake_pulse,
  input wire logic handler_defer
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic wake_int;
  assign wake_int = exc_entry_req | debug_wake
                  | (irq_above_priority & interrupt_disable_flag & ~fault_disable_flag);
  chk_light_gate:
    assert property (sleeping && !deep_sleep |-> sys_clk_en && !pll_power_down
      && !flash_power_down) else $error("light sleep clocks wrong");
  chk_deep_power:
    assert property (deep_sleep |-> sleeping && !sys_clk_en && pll_power_down
      && flash_power_down) else $error("deep sleep power wrong");
  chk_wfi_entry:
    assert property (!sleeping && wait_for_interrupt_instr && !wake_int |=> sleeping)
      else $error("wfi did not sleep");
  chk_wfi_refused:
    assert property (!sleeping && wait_for_interrupt_instr && wake_int |=> !sleeping)
      else $error("wfi slept with wake pending");
  chk_wfe_outcome:
    assert property (!sleeping && wait_for_event_instr && !wait_for_interrupt_instr
      |=> sleeping != wfe_skip) else $error("wfe neither slept nor skipped");
  chk_skip_cause:
    assert property (wfe_skip |-> $past(wait_for_event_instr) && !core_halt)
      else $error("stray skip");
  chk_wake_exc:
    assert property (sleeping && exc_entry_req |=> !sleeping && wake_pulse)
      else $error("no wake on exception");
  chk_stay_asleep:
    assert property (sleeping && $past(sleeping) && !wake_int && !send_event_instr
      && !irq_new_pending && !$past(send_event_instr) && !$past(irq_new_pending)
      |=> sleeping) else $error("woke without cause");
  chk_wake_pulse:
    assert property ($fell(sleeping) |-> wake_pulse ##1 !wake_pulse)
      else $error("wake pulse wrong");
  chk_defer_clear:
    assert property (handler_defer && !interrupt_disable_flag |=> !handler_defer)
      else $error("defer stuck");
  chk_halt_match:
    assert property (core_halt == sleeping && core_clk_en != sleeping)
      else $error("halt and clock disagree");
  cover property (deep_sleep);
  cover property (wfe_skip);
  cover property (handler_defer);
endmodule

bind pswc_top pswc_checker u_chk (.*);

// File: tb/pswc_irq_model.sv
// Purpose: Interrupt controller model facing the sleep controller
// Assumes: Bench commands change right after rising edges
// Notes:   One pending line; enable and priority are levels
module pswc_irq_model (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic raise,
  input  wire logic ack,
  input  wire logic enable,
  input  wire logic prio_ok,
  input  wire logic mask,
  output logic      exc_entry_req,
  output logic      irq_above_priority,
  output logic      irq_new_pending
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend <= 1'h0;
    end else begin
      pend <= (pend | raise) & ~ack;
    end
  end
  assign irq_new_pending    = raise & ~pend;
  assign irq_above_priority = pend & enable & prio_ok;
  assign exc_entry_req      = irq_above_priority & ~mask;
endmodule

// File: tb/processor_sleep_wake_control_tb_top.sv
// Purpose: Self-checking bench for the sleep and wake controller
// Assumes: Interrupt side comes from pswc_irq_model
// Notes:   Inputs change by non-blocking assignment after rising edges
module processor_sleep_wake_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pswc_pkg::*;
  typedef struct packed {
    logic [4:0] ctrl; logic [9:0] lvl; logic [9:0] go; logic [9:0] wk;
    logic deep; logic [1:0] st; logic [2:0] cause; logic dfr;
  } pswc_row_t;
  logic        clock, resetn, reg_write, reg_read, exc, above, newp, fdf;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [9:0]  drv, lv;
  logic        core_halt, core_clk_en, sys_clk_en, pll_power_down, flash_power_down;
  logic        sleeping, deep_sleep, wfe_skip, wake_pulse, handler_defer;
  int          n_fail, compares;
  pswc_row_t   rows [7];
  pswc_top u_dut (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .wait_for_interrupt_instr(drv[0]), .wait_for_event_instr(drv[1]),
    .send_event_instr(drv[2]), .handler_exit_last(drv[3]), .debug_wake(drv[4]),
    .exc_entry_req(exc), .irq_above_priority(above), .irq_new_pending(newp),
    .interrupt_disable_flag(drv[9]), .fault_disable_flag(fdf),
    .core_halt(core_halt), .core_clk_en(core_clk_en), .sys_clk_en(sys_clk_en),
    .pll_power_down(pll_power_down), .flash_power_down(flash_power_down),
    .sleeping(sleeping), .deep_sleep(deep_sleep), .wfe_skip(wfe_skip),
    .wake_pulse(wake_pulse), .handler_defer(handler_defer)
  );
  pswc_irq_model u_irq (
    .clock(clock), .resetn(resetn), .raise(drv[5]), .ack(drv[6]), .enable(drv[7]),
    .prio_ok(drv[8]), .mask(drv[9]), .exc_entry_req(exc),
    .irq_above_priority(above), .irq_new_pending(newp)
  );
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic pulse(input logic [9:0] m);
    @(posedge clock);
    drv <= lv | m;
    @(posedge clock);
    drv <= lv;
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  task automatic wait_wake();
    int k;
    k = 0;
    while (wake_pulse !== 1'h1 && k < 4) begin
      @(negedge clock);
      k++;
    end
    cmp("wake", 1, wake_pulse);
    cmp("sleeping", 0, sleeping);
  endtask
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    end_sim();
  end
  initial begin
    rows = '{
      '{5'h00, 10'h180, 10'h001, 10'h020, 1'h0, 2'h1, PSWC_CAUSE_EXC, 1'h0},
      '{5'h04, 10'h180, 10'h001, 10'h020, 1'h1, 2'h1, PSWC_CAUSE_EXC, 1'h0},
      '{5'h06, 10'h180, 10'h008, 10'h010, 1'h1, 2'h1, PSWC_CAUSE_DEBUG, 1'h0},
      '{5'h00, 10'h380, 10'h001, 10'h020, 1'h0, 2'h1, PSWC_CAUSE_DEFER, 1'h1},
      '{5'h00, 10'h180, 10'h002, 10'h004, 1'h0, 2'h2, PSWC_CAUSE_EVENT, 1'h0},
      '{5'h10, 10'h000, 10'h002, 10'h020, 1'h0, 2'h2, PSWC_CAUSE_EVENT, 1'h0},
      '{5'h00, 10'h180, 10'h002, 10'h020, 1'h0, 2'h2, PSWC_CAUSE_EXC, 1'h0}};
    resetn = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_write = 1'h0;
    reg_read = 1'h0;
    drv = 10'h000;
    lv = 10'h000;
    fdf = 1'h0;
    repeat (6) @(posedge clock);
    resetn <= 1'h1;
    @(negedge clock);
    cmp("sleeping", 0, sleeping);
    cmp("sys_clk", 1, sys_clk_en);
    rd(8'h00, d);
    cmp("ctrl", 0, d);
    $display("reset test done");
    foreach (rows[i]) begin
      lv = rows[i].lvl;
      wr(8'h00, {27'h0, rows[i].ctrl});
      pulse(rows[i].go);
      cmp("sleeping", 1, sleeping);
      cmp("core_clk", 0, core_clk_en);
      cmp("halt", 1, core_halt);
      cmp("deep", rows[i].deep, deep_sleep);
      cmp("sys_clk", !rows[i].deep, sys_clk_en);
      cmp("flash", rows[i].deep, flash_power_down);
      cmp("pll", rows[i].deep, pll_power_down);
      rd(8'h04, d);
      cmp("state", rows[i].st, d[1:0]);
      pulse(rows[i].wk);
      wait_wake();
      cmp("defer", rows[i].dfr, handler_defer);
      rd(8'h04, d);
      cmp("cause", rows[i].cause, d[6:4]);
      lv = 10'h180;
      pulse(10'h040);
      cmp("defer", 0, handler_defer);
      $display("row %0d done", i);
    end
    wr(8'h00, 32'h0000_0000);
    pulse(10'h020);
    pulse(10'h001);
    cmp("sleeping", 0, sleeping);
    pulse(10'h040);
    pulse(10'h004);
    pulse(10'h002);
    cmp("skip", 1, wfe_skip);
    cmp("sleeping", 0, sleeping);
    pulse(10'h002);
    cmp("sleeping", 1, sleeping);
    $display("event latch test done");
    lv = 10'h000;
    pulse(10'h020);
    repeat (3) @(negedge clock);
    cmp("sleeping", 1, sleeping);
    pulse(10'h010);
    wait_wake();
    pulse(10'h001);
    cmp("sleeping", 1, sleeping);
    lv = 10'h180;
    pulse(10'h040);
    wait_wake();
    lv = 10'h380;
    @(posedge clock);
    fdf <= 1'h1;
    pulse(10'h001);
    pulse(10'h020);
    repeat (3) @(negedge clock);
    cmp("sleeping", 1, sleeping);
    cmp("defer", 0, handler_defer);
    lv = 10'h180;
    pulse(10'h040);
    wait_wake();
    rd(8'h08, d);
    cmp("entries", 32'h0000_000A, d);
    rd(8'h0C, d);
    cmp("wakes", 32'h0000_000A, d);
    wr(8'h08, 32'h0000_0000);
    rd(8'h08, d);
    cmp("entries", 0, d);
    rd(8'h10, d);
    cmp("unmapped", 0, d);
    $display("wake test done");
    end_sim();
  end
endmodule
